// ### verilog/asc_pkg.sv
package asc_pkg;
    localparam logic [7:0] ADDR_MODE1 = 8'h00;
    localparam logic [7:0] ADDR_MODE2 = 8'h04;
    localparam logic [7:0] ADDR_CLKSEL = 8'h08;
    localparam logic [7:0] ADDR_CMD = 8'h0C;
    localparam logic [7:0] ADDR_STAT = 8'h10;
    localparam logic [7:0] ADDR_DATA = 8'h14;
    localparam logic [7:0] ADDR_BAUD = 8'h18;
    localparam logic [7:0] ADDR_CTR = 8'h1C;

    localparam int M1_AUTO_RTS = 7;
    localparam int M1_IRQ_FULL = 6;
    localparam int M1_BLOCK = 5;
    localparam int M1_PTYPE = 2;
    localparam int M2_STOP2 = 0;
    localparam int M2_CTS_EN = 4;

    localparam int CMD_RX_EN = 0;
    localparam int CMD_RX_DIS = 1;
    localparam int CMD_TX_EN = 2;
    localparam int CMD_TX_DIS = 3;
    localparam logic [3:0] CMD_RST_RX = 4'h1;
    localparam logic [3:0] CMD_RST_TX = 4'h2;
    localparam logic [3:0] CMD_RST_ERR = 4'h3;
    localparam logic [3:0] CMD_BRK_ON = 4'h4;
    localparam logic [3:0] CMD_BRK_OFF = 4'h5;
    localparam logic [3:0] CMD_RTS_ON = 4'h6;
    localparam logic [3:0] CMD_RTS_OFF = 4'h7;

    localparam logic [7:0] MODE1_RST = 8'h00;
    localparam logic [7:0] MODE2_RST = 8'h00;
    localparam logic [7:0] CLKSEL_RST = 8'h00;
    localparam logic [15:0] DIV_RST = 16'h0000;

    // Sixteen sub-ticks per bit; the start check falls on the eighth.
    localparam logic [3:0] SUB_FULL16 = 4'hF;
    localparam logic [3:0] SUB_HALF16 = 4'h7;
    localparam logic [1:0] BRK_HIGH_CNT = 2'h2;
    localparam logic [1:0] QUEUE_LAST = 2'h2;
    localparam logic [1:0] QUEUE_FULL = 2'h3;

    typedef enum logic [1:0] {
        SRC_BAUD = 2'b00, SRC_CTR = 2'b01, SRC_EXT16 = 2'b10, SRC_EXT1 = 2'b11
    } asc_src_t;
    typedef enum logic [1:0] {
        PAR_WITH = 2'b00, PAR_FORCE = 2'b01, PAR_NONE = 2'b10, PAR_WAKE = 2'b11
    } asc_par_t;
    typedef enum logic [2:0] {
        TX_IDLE = 3'b000, TX_START = 3'b001, TX_DATA = 3'b010, TX_PAR = 3'b011,
        TX_STOP = 3'b100
    } asc_tx_st_t;
    typedef enum logic [2:0] {
        RX_HUNT = 3'b000, RX_START = 3'b001, RX_DATA = 3'b010, RX_PAR = 3'b011,
        RX_STOP = 3'b100, RX_FEWAIT = 3'b101, RX_BRK = 3'b110
    } asc_rx_st_t;

    typedef struct packed {
        logic brk;
        logic fe;
        logic pe;
        logic [7:0] data;
    } asc_entry_t;

    typedef struct packed {
        logic [7:0] mode1;
        logic [7:0] mode2;
        logic [7:0] clksel;
        logic [15:0] baud_div;
        logic [15:0] ctr_div;
        logic [15:0] baud_cnt;
        logic [15:0] ctr_cnt;
        logic rx_s1, rx_s2, rx_s3;
        logic ext_s1, ext_s2, ext_s3;
        logic cts_s1, cts_s2;
        logic ack;
        logic [31:0] prdata;
        logic tx_en, rx_en, brk, rts_on, auto_neg, rts_n, txd, line;
        logic [7:0] tx_hold_reg;
        logic thr_full;
        asc_tx_st_t tx_st;
        logic [3:0] tx_sub;
        logic [2:0] tx_bit;
        logic [7:0] tx_sh;
        logic tx_par;
        asc_rx_st_t rx_st;
        logic [3:0] rx_sub;
        logic [2:0] rx_bit;
        logic [7:0] rx_sh;
        logic rx_pe, rx_nz;
        logic [1:0] hi_cnt;
        logic [1:0] wr_ptr, rd_ptr, count;
        logic avail, ovr;
        logic [2:0] acc;
    } asc_state_t;
endpackage

// ### verilog/asc_mem.sv
`timescale 1ns/10ps
module asc_mem import asc_pkg::*; #(
    parameter int DEPTH = 3,
    parameter int AW = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire asc_entry_t wdata,
    input wire logic [AW-1:0] raddr,
    output asc_entry_t rdata
);
    typedef struct packed {
        asc_entry_t [DEPTH-1:0] mem;
        asc_entry_t rd;
    } asc_mem_state_t;

    asc_mem_state_t r, next_r;

    // Contents survive a receiver reset; only pointers move.
    always_comb begin
        next_r = r;
        if (we) begin
            next_r.mem[waddr] = wdata;
        end
        next_r.rd = r.mem[raddr];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign rdata = r.rd;
endmodule

// ### verilog/asc_chan.sv
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
module asc_chan import asc_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rxd,
    output logic txd,
    input wire logic ext_clk,
    input wire logic clear_to_send_n,
    output logic send_request_n,
    output logic rx_avail_flag,
    output logic rx_queue_full_flag,
    output logic tx_idle_flag,
    output logic rx_event
);
    asc_state_t r, n;
    asc_entry_t head, push_e;
    logic push, push_ok, pop, acc_ph, commit, wr_c, rd_c, addr_ok;
    logic baud_tick, ctr_tick, ext_tick, tx_tick, rx_tick, tx_end, rx_mid;
    logic rx_in, fall, cts_ok, par_on, full;
    logic [3:0] tx_full, rx_full, rx_half;
    logic [2:0] nbits_m1;
    logic [7:0] mask, rx_data, stat;
    logic [31:0] rd_val;
    asc_src_t tx_src, rx_src;
    asc_par_t par_mode;

    function automatic logic pick(asc_src_t s, logic b, logic c, logic e);
        unique case (s)
            SRC_BAUD: pick = b;
            SRC_CTR: pick = c;
            SRC_EXT16, SRC_EXT1: pick = e;
        endcase
    endfunction

    function automatic logic [1:0] inc3(logic [1:0] p);
        inc3 = (p == QUEUE_LAST) ? 2'h0 : p + 2'h1;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Bus side: every access takes one wait state so read data come from a flop.
    assign acc_ph = psel & penable;
    assign commit = acc_ph & r.ack;
    assign wr_c = commit & pwrite;
    assign rd_c = commit & ~pwrite;
    assign addr_ok = (paddr[1:0] == 2'h0) && (paddr <= ADDR_CTR);
    assign pready = r.ack;
    assign pslverr = r.ack & ~addr_ok;
    assign prdata = r.prdata;
    assign pop = rd_c && (paddr == ADDR_DATA);

    ////////////////////////////////////////////////////////////////////////////
    // Bit clocks and character format.
    assign baud_tick = (r.baud_cnt == 16'h0000);
    assign ctr_tick = (r.ctr_cnt == 16'h0000);
    assign ext_tick = r.ext_s2 & ~r.ext_s3;
    assign tx_src = asc_src_t'(r.clksel[3:2]);
    assign rx_src = asc_src_t'(r.clksel[1:0]);
    assign tx_tick = pick(tx_src, baud_tick, ctr_tick, ext_tick);
    assign rx_tick = pick(rx_src, baud_tick, ctr_tick, ext_tick);
    assign tx_full = (tx_src == SRC_EXT1) ? 4'h0 : SUB_FULL16;
    assign rx_full = (rx_src == SRC_EXT1) ? 4'h0 : SUB_FULL16;
    assign rx_half = (rx_src == SRC_EXT1) ? 4'h0 : SUB_HALF16;
    assign tx_end = tx_tick && (r.tx_sub == tx_full);
    assign rx_mid = rx_tick && (r.rx_sub == rx_full);
    assign nbits_m1 = {1'b1, r.mode1[1:0]};
    assign mask = 8'hFF >> (2'h3 - r.mode1[1:0]);
    assign rx_data = r.rx_sh >> (2'h3 - r.mode1[1:0]);
    assign par_mode = asc_par_t'(r.mode1[4:3]);
    assign par_on = (par_mode != PAR_NONE);
    assign rx_in = r.rx_s2;
    assign fall = r.rx_s3 & ~r.rx_s2;
    assign cts_ok = ~r.mode2[M2_CTS_EN] | ~r.cts_s2;
    assign full = (r.count == QUEUE_FULL);

    ////////////////////////////////////////////////////////////////////////////
    // Status and read mux.
    always_comb begin
        stat = '0;
        stat[0] = r.avail;
        stat[1] = full;
        stat[2] = ~r.thr_full;
        stat[3] = tx_idle_flag;
        stat[4] = r.ovr;
        if (r.mode1[M1_BLOCK]) begin
            stat[7:5] = r.acc;
        end else begin
            stat[7:5] = {head.brk, head.fe, head.pe} & {3{r.avail}};
        end
        unique case (paddr)
            ADDR_MODE1: rd_val = {24'h000000, r.mode1};
            ADDR_MODE2: rd_val = {24'h000000, r.mode2};
            ADDR_CLKSEL: rd_val = {24'h000000, r.clksel};
            ADDR_STAT: rd_val = {24'h000000, stat};
            ADDR_DATA: rd_val = {24'h000000, head.data};
            ADDR_BAUD: rd_val = {16'h0000, r.baud_div};
            ADDR_CTR: rd_val = {16'h0000, r.ctr_div};
            default: rd_val = 32'h00000000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        n = r;
        push = 1'b0;
        push_e = '0;
        n.rx_s1 = rxd;
        n.rx_s2 = r.rx_s1;
        n.rx_s3 = r.rx_s2;
        n.ext_s1 = ext_clk;
        n.ext_s2 = r.ext_s1;
        n.ext_s3 = r.ext_s2;
        n.cts_s1 = clear_to_send_n;
        n.cts_s2 = r.cts_s1;
        n.baud_cnt = baud_tick ? r.baud_div : r.baud_cnt - 16'h0001;
        n.ctr_cnt = ctr_tick ? r.ctr_div : r.ctr_cnt - 16'h0001;
        n.ack = acc_ph & ~r.ack;
        if (acc_ph && !r.ack) begin
            n.prdata = rd_val;
        end

        // Transmitter.
        if (r.tx_st != TX_IDLE && tx_tick) begin
            n.tx_sub = tx_end ? 4'h0 : r.tx_sub + 4'h1;
        end
        unique case (r.tx_st)
            TX_IDLE: begin
                n.line = 1'b1;
                if (r.thr_full && cts_ok) begin
                    // Sub-tick count restarts here so the start bit goes out at once.
                    n.tx_st = TX_START;
                    n.tx_sub = 4'h0;
                    n.tx_sh = r.tx_hold_reg;
                    n.tx_par = (par_mode == PAR_WITH) ?
                        (^(r.tx_hold_reg & mask) ^ r.mode1[M1_PTYPE]) : r.mode1[M1_PTYPE];
                    n.thr_full = 1'b0;
                    n.line = 1'b0;
                end
            end
            TX_START: begin
                if (tx_end) begin
                    n.tx_st = TX_DATA;
                    n.tx_bit = 3'h0;
                    n.line = r.tx_sh[0];
                end
            end
            TX_DATA: begin
                if (tx_end) begin
                    if (r.tx_bit == nbits_m1) begin
                        n.tx_st = par_on ? TX_PAR : TX_STOP;
                        n.line = par_on ? r.tx_par : 1'b1;
                        n.tx_bit = 3'h0;
                    end else begin
                        n.tx_bit = r.tx_bit + 3'h1;
                        n.tx_sh = r.tx_sh >> 1;
                        n.line = r.tx_sh[1];
                    end
                end
            end
            TX_PAR: begin
                if (tx_end) begin
                    n.tx_st = TX_STOP;
                    n.line = 1'b1;
                end
            end
            TX_STOP: begin
                if (tx_end) begin
                    if (r.mode2[M2_STOP2] && r.tx_bit == 3'h0) begin
                        n.tx_bit = 3'h1;
                    end else begin
                        n.tx_st = TX_IDLE;
                    end
                end
            end
            default: n.tx_st = TX_IDLE;
        endcase

        // Receiver.
        if ((r.rx_st == RX_DATA || r.rx_st == RX_PAR || r.rx_st == RX_STOP) && rx_tick) begin
            n.rx_sub = rx_mid ? 4'h0 : r.rx_sub + 4'h1;
        end
        if (!r.rx_en) begin
            n.rx_st = RX_HUNT;
        end else begin
            unique case (r.rx_st)
                RX_HUNT: begin
                    if (fall) begin
                        n.rx_st = RX_START;
                        n.rx_sub = 4'h0;
                    end
                end
                RX_START: begin
                    if (rx_tick) begin
                        if (r.rx_sub != rx_half) begin
                            n.rx_sub = r.rx_sub + 4'h1;
                        end else if (rx_in) begin
                            n.rx_st = RX_HUNT;
                        end else begin
                            n.rx_st = RX_DATA;
                            n.rx_sub = 4'h0;
                            n.rx_bit = 3'h0;
                            n.rx_sh = 8'h00;
                            n.rx_nz = 1'b0;
                            n.rx_pe = 1'b0;
                            if (r.mode1[M1_AUTO_RTS] && full) begin
                                n.auto_neg = 1'b1;
                            end
                        end
                    end
                end
                RX_DATA: begin
                    if (rx_mid) begin
                        n.rx_sh = {rx_in, r.rx_sh[7:1]};
                        n.rx_nz = r.rx_nz | rx_in;
                        if (r.rx_bit == nbits_m1) begin
                            n.rx_st = par_on ? RX_PAR : RX_STOP;
                        end else begin
                            n.rx_bit = r.rx_bit + 3'h1;
                        end
                    end
                end
                RX_PAR: begin
                    if (rx_mid) begin
                        n.rx_nz = r.rx_nz | rx_in;
                        n.rx_st = RX_STOP;
                        unique case (par_mode)
                            PAR_WITH: n.rx_pe = rx_in ^ ^rx_data ^ r.mode1[M1_PTYPE];
                            PAR_FORCE: n.rx_pe = rx_in ^ r.mode1[M1_PTYPE];
                            PAR_NONE, PAR_WAKE: n.rx_pe = rx_in;
                        endcase
                    end
                end
                RX_STOP: begin
                    if (rx_mid) begin
                        push = 1'b1;
                        push_e.data = rx_data;
                        push_e.pe = r.rx_pe;
                        if (rx_in) begin
                            n.rx_st = RX_HUNT;
                        end else if (!r.rx_nz) begin
                            push_e.brk = 1'b1;
                            push_e.pe = 1'b0;
                            n.rx_st = RX_BRK;
                            n.hi_cnt = 2'h0;
                        end else begin
                            push_e.fe = 1'b1;
                            n.rx_st = RX_FEWAIT;
                        end
                    end
                end
                RX_FEWAIT: begin
                    if (rx_tick) begin
                        if (r.rx_sub != rx_half) begin
                            n.rx_sub = r.rx_sub + 4'h1;
                        end else begin
                            n.rx_st = rx_in ? RX_HUNT : RX_START;
                            n.rx_sub = 4'h0;
                        end
                    end
                end
                RX_BRK: begin
                    // Counted on the system clock, so the line need only be high briefly.
                    n.hi_cnt = rx_in ? r.hi_cnt + 2'h1 : 2'h0;
                    if (rx_in && (r.hi_cnt + 2'h1 == BRK_HIGH_CNT)) begin
                        n.rx_st = RX_HUNT;
                    end
                end
                default: n.rx_st = RX_HUNT;
            endcase
        end

        // Queue: a push into a full queue is lost and flagged as overrun.
        push_ok = push && !full;
        if (push && full) begin
            n.ovr = 1'b1;
        end
        if (push_ok) begin
            n.wr_ptr = inc3(r.wr_ptr);
        end
        if (pop) begin
            // An extra read still advances the pointer; a receiver reset repairs it.
            n.rd_ptr = inc3(r.rd_ptr);
        end
        if (push_ok && !(pop && r.count != 2'h0)) begin
            n.count = r.count + 2'h1;
        end else if (!push_ok && pop && r.count != 2'h0) begin
            n.count = r.count - 2'h1;
        end
        n.avail = (r.count != 2'h0);
        if (r.avail) begin
            n.acc = r.acc | {head.brk, head.fe, head.pe};
        end
        if (!full) begin
            n.auto_neg = 1'b0;
        end

        // Register writes, applied at the completing edge.
        if (wr_c) begin
            unique case (paddr)
                ADDR_MODE1: n.mode1 = pwdata[7:0];
                ADDR_MODE2: n.mode2 = pwdata[7:0];
                ADDR_CLKSEL: n.clksel = pwdata[7:0];
                ADDR_BAUD: n.baud_div = pwdata[15:0];
                ADDR_CTR: n.ctr_div = pwdata[15:0];
                ADDR_DATA: begin
                    if (r.tx_en) begin
                        n.tx_hold_reg = pwdata[7:0];
                        n.thr_full = 1'b1;
                    end
                end
                ADDR_CMD: begin
                    if (pwdata[CMD_RX_EN]) n.rx_en = 1'b1;
                    if (pwdata[CMD_RX_DIS]) n.rx_en = 1'b0;
                    if (pwdata[CMD_TX_EN]) n.tx_en = 1'b1;
                    if (pwdata[CMD_TX_DIS]) n.tx_en = 1'b0;
                    unique case (pwdata[7:4])
                        CMD_RST_RX: begin
                            n.rx_st = RX_HUNT;
                            n.rx_en = 1'b0;
                            n.rd_ptr = n.wr_ptr;
                            n.count = 2'h0;
                        end
                        CMD_RST_TX: begin
                            n.tx_st = TX_IDLE;
                            n.thr_full = 1'b0;
                            n.tx_en = 1'b0;
                            n.line = 1'b1;
                        end
                        CMD_RST_ERR: begin
                            n.ovr = push && full;
                            n.acc = 3'h0;
                        end
                        CMD_BRK_ON: n.brk = 1'b1;
                        CMD_BRK_OFF: n.brk = 1'b0;
                        CMD_RTS_ON: n.rts_on = 1'b1;
                        CMD_RTS_OFF: n.rts_on = 1'b0;
                        default: ;
                    endcase
                end
                default: ;
            endcase
        end
        n.txd = r.brk ? 1'b0 : n.line;
        n.rts_n = ~r.rts_on | r.auto_neg;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.mode1 <= MODE1_RST;
            r.mode2 <= MODE2_RST;
            r.clksel <= CLKSEL_RST;
            r.baud_div <= DIV_RST;
            r.ctr_div <= DIV_RST;
            r.rx_s1 <= 1'b1;
            r.rx_s2 <= 1'b1;
            r.rx_s3 <= 1'b1;
            r.txd <= 1'b1;
            r.line <= 1'b1;
            r.rts_n <= 1'b1;
        end else begin
            r <= n;
        end
    end

    asc_mem #(.DEPTH(3), .AW(2)) u_mem (
        .pclk(pclk),
        .presetn(presetn),
        .we(push_ok),
        .waddr(r.wr_ptr),
        .wdata(push_e),
        .raddr(r.rd_ptr),
        .rdata(head)
    );

    assign txd = r.txd;
    assign send_request_n = r.rts_n;
    assign rx_avail_flag = r.avail;
    assign rx_queue_full_flag = full;
    assign tx_idle_flag = (r.tx_st == TX_IDLE) && !r.thr_full;
    assign rx_event = r.mode1[M1_IRQ_FULL] ? full : r.avail;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_tx_start_low: assert property (r.tx_st == TX_START && !$past(r.brk) |-> !txd)
        else $error("start bit not low");
    a_idle_line_high: assert property (tx_idle_flag && !$past(r.brk) |-> txd)
        else $error("idle line not high");
    a_break_holds: assert property (r.brk |=> !txd)
        else $error("break not holding line low");
    a_thr_refused: assert property (wr_c && paddr == ADDR_DATA && !r.tx_en && !r.thr_full
        |=> !r.thr_full)
        else $error("holding write taken while disabled");
    a_start_reject: assert property (r.rx_en && r.rx_st == RX_START && rx_tick
        && r.rx_sub == rx_half && rx_in |=> r.rx_st == RX_HUNT)
        else $error("false start not rejected");
    a_overrun_set: assert property (push && full |=> r.ovr)
        else $error("overrun not flagged");
    a_avail_follows: assert property (r.count != 2'h0 |=> rx_avail_flag)
        else $error("available flag missing");
    a_pop_ptr: assert property (pop |=> r.rd_ptr == inc3($past(r.rd_ptr)))
        else $error("read did not pop");
    a_rts_negated: assert property (r.auto_neg |=> send_request_n)
        else $error("request-to-send not negated");
    a_disable_stops: assert property (!r.rx_en |=> r.rx_st == RX_HUNT)
        else $error("receiver ran while disabled");
endmodule

// ### verif/asc_remote.sv
`timescale 1ns/10ps
// Remote station. With divisor 0 and the 16X source, one bit lasts 16 pclk cycles.
module asc_remote (
    input wire logic pclk,
    input wire logic txd,
    output logic rxd
);
    logic [7:0] got;
    initial rxd = 1'b1;
    // A low stop bit with all-zero data makes a break; the line then returns high.
    task automatic send(input logic [7:0] b, input int nb, input logic stp);
        logic [9:0] f;
        f = {1'b0, b, 1'b0};
        f[nb + 1] = stp;
        for (int i = 0; i < nb + 2; i++) begin
            rxd <= f[i];
            repeat (16) @(posedge pclk);
        end
        if (!stp) begin
            rxd <= 1'b1;
        end
    endtask
    // A short low pulse; long enough a wait that a wrongly taken start would be queued.
    task automatic glitch();
        rxd <= 1'b0;
        repeat (4) @(posedge pclk);
        rxd <= 1'b1;
        repeat (180) @(posedge pclk);
    endtask
    // Data bits are taken at their centres, so edge jitter of a cycle is harmless.
    task automatic take();
        while (txd !== 1'b0) @(posedge pclk);
        repeat (8) @(posedge pclk);
        for (int i = 0; i < 8; i++) begin
            repeat (16) @(posedge pclk);
            got[i] = txd;
        end
    endtask
endmodule

// ### verif/tb_async_serial_channel.sv
`timescale 1ns/10ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin miscompares++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_async_serial_channel import asc_pkg::*;;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, txd, rxd, err;
    logic send_request_n, rx_avail_flag, rx_queue_full_flag, tx_idle_flag, rx_event;
    logic [7:0] paddr, b;
    logic [31:0] pwdata, prdata, r, seed;
    logic [7:0] q[$];
    int miscompares, comparisons;
    asc_chan i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxd(rxd), .txd(txd), .ext_clk(1'b0), .clear_to_send_n(1'b0),
        .send_request_n(send_request_n), .rx_avail_flag(rx_avail_flag),
        .rx_queue_full_flag(rx_queue_full_flag), .tx_idle_flag(tx_idle_flag),
        .rx_event(rx_event));
    asc_remote u_far (.pclk(pclk), .txd(txd), .rxd(rxd));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic give_verdict();
        $display("compared %0d, mismatched %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        give_verdict();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        seed = 32'h70BE;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        `CHK(txd, 1'b1)
        apb(1'b1, ADDR_CMD, 32'h05);
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, ADDR_MODE1, 32'h10 | m);
            void'(rnd());
            b = seed[7:0];
            u_far.send(b, m + 5, 1'b1);
            apb(1'b0, ADDR_DATA, 32'h0);
            `CHK(r[7:0], b & (8'hFF >> (3 - m)))
        end
        $display("test char_length done");
        apb(1'b1, ADDR_CMD, {24'h0, CMD_RTS_ON, 4'h0});
        apb(1'b1, ADDR_MODE1, 32'hD3);
        `CHK(send_request_n, 1'b0)
        for (int i = 0; i < 4; i++) begin
            void'(rnd());
            if (i < 3) begin
                q.push_back(seed[7:0]);
            end
            u_far.send(seed[7:0], 8, 1'b1);
            `CHK(rx_event, i >= 2)
        end
        repeat (4) @(posedge pclk);
        `CHK(rx_queue_full_flag, 1'b1)
        `CHK(send_request_n, 1'b1)
        apb(1'b0, ADDR_STAT, 32'h0);
        `CHK(r[1:0], 2'b11)
        `CHK(r[4], 1'b1)
        while (q.size() > 0) begin
            apb(1'b0, ADDR_DATA, 32'h0);
            `CHK(r[7:0], q.pop_front())
        end
        repeat (3) @(posedge pclk);
        `CHK(rx_avail_flag, 1'b0)
        `CHK(send_request_n, 1'b0)
        u_far.glitch();
        `CHK(rx_avail_flag, 1'b0)
        $display("test rx_queue done");
        void'(rnd());
        b = seed[7:0];
        fork
            u_far.take();
            apb(1'b1, ADDR_DATA, {24'h0, b});
        join
        `CHK(u_far.got, b)
        repeat (40) @(posedge pclk);
        `CHK(tx_idle_flag, 1'b1)
        apb(1'b1, ADDR_CMD, 32'h08);
        apb(1'b1, ADDR_DATA, {24'h0, b});
        apb(1'b1, ADDR_CMD, 32'h04);
        `CHK(tx_idle_flag, 1'b1)
        apb(1'b1, ADDR_CMD, {24'h0, CMD_BRK_ON, 4'h0});
        repeat (60) @(posedge pclk);
        `CHK(txd, 1'b0)
        apb(1'b1, ADDR_CMD, {24'h0, CMD_BRK_OFF, 4'h0});
        repeat (4) @(posedge pclk);
        `CHK(txd, 1'b1)
        $display("test transmit done");
        u_far.send(8'h00, 8, 1'b0);
        repeat (8) @(posedge pclk);
        apb(1'b0, ADDR_STAT, 32'h0);
        `CHK(r[7], 1'b1)
        apb(1'b0, ADDR_DATA, 32'h0);
        `CHK(r[7:0], 8'h00)
        repeat (3) @(posedge pclk);
        `CHK(rx_avail_flag, 1'b0)
        apb(1'b0, 8'h20, 32'h0);
        `CHK(err, 1'b1)
        $display("test break done");
        give_verdict();
    end
endmodule
